/* File: scbc_pkg.sv */
// Purpose: shared constants and types for the serial channel clocking block
// Assumes: 50 MHz system clock, AXI4-Lite register access
// Notes:   offsets are byte addresses of aligned 32-bit words
package scbc_pkg;
    // register byte offsets
    localparam logic [7:0] OFF_MODE     = 8'h00; // serial_mode_reg
    localparam logic [7:0] OFF_BAUD     = 8'h04; // baud_control_reg
    localparam logic [7:0] OFF_FRAC     = 8'h08; // baud_fraction_reg
    localparam logic [7:0] OFF_CLKCFG   = 8'h0C; // system_clock_config
    localparam logic [7:0] OFF_STATUS   = 8'h10; // live clock status
    localparam logic [7:0] OFF_WAKE     = 8'h14; // wakeup frame test
    // serial_mode_reg fields
    localparam int MODE_LSB   = 0;  // 2-bit frame mode
    localparam int SRC_LSB    = 2;  // 2-bit uart_clock_source
    localparam int PAR_BIT    = 4;  // parity enable
    localparam int DIR_BIT    = 5;  // clock_pin_direction, 1 = input
    // baud_control_reg fields
    localparam int DIV_LSB    = 0;  // 4-bit integer_divisor
    localparam int TAP_LSB    = 4;  // 2-bit prescaler_tap_select
    localparam int FEN_BIT    = 6;  // fraction_enable
    // system_clock_config fields
    localparam int GEAR_LSB   = 0;  // 3-bit clock_gear_select
    localparam int SLOW_BIT   = 3;  // slow clock selected
    // reset values
    localparam logic [5:0] RST_MODE  = 6'h00;
    localparam logic [6:0] RST_BAUD  = 7'h00;
    localparam logic [3:0] RST_FRAC  = 4'h0;
    localparam logic [3:0] RST_CLK   = 4'h0;
    // external clock minimum periods in system clocks, then oversampling, prescaler width and largest gear
    localparam int EXT_MIN_ASYNC = 4;
    localparam int EXT_MIN_SYNC  = 16;
    localparam int OVERSAMPLE    = 16;
    localparam int PRESC_BITS    = 6;
    localparam int GEAR_MAX      = 4;

    typedef enum logic [1:0] {SCBC_SHIFT, SCBC_ASYNC7, SCBC_ASYNC8, SCBC_ASYNC9} scbc_mode_e;
    typedef enum logic [1:0] {SCBC_SRC_BRG, SCBC_SRC_IO, SCBC_SRC_TMR, SCBC_SRC_EXT} scbc_src_e;

    typedef struct packed {
        logic [1:0] tap;
        logic       fen;
        logic [3:0] n;
        logic [3:0] k;
    } scbc_baud_s;
endpackage

/* File: scbc_presc.sv */
// Purpose: gear divider and 6-bit prescaler producing the four tap strobes
// Assumes: gear value above the largest legal one acts as the largest
// Notes:   strobes are one system clock wide
`timescale 1ns/10ps
module scbc_presc (
    input  wire logic       clk,
    input  wire logic       sys_rst,
    input  wire logic [2:0] gear,
    input  wire logic       slow_sel,
    input  wire logic       slow_tick,
    output logic      [3:0] taps
);
    logic [3:0]                      gear_cnt_q;
    logic [scbc_pkg::PRESC_BITS-1:0] presc_q;
    logic [3:0]                      taps_q;
    logic [2:0]                      gear_eff;
    logic [3:0]                      gear_mask;
    logic                            gear_tick;
    logic                            base_tick;
    logic [scbc_pkg::PRESC_BITS-1:0] presc_nx;
    logic [2:0]                      pre_q;

    // gear divides by 2^gear; slow clock bypasses the gear
    assign gear_eff  = (gear > 3'(scbc_pkg::GEAR_MAX)) ? 3'(scbc_pkg::GEAR_MAX) : gear;
    assign gear_mask = 4'((5'h01 << gear_eff) - 5'h01);
    assign gear_tick = ((gear_cnt_q & gear_mask) == gear_mask);
    assign base_tick = slow_sel ? slow_tick : gear_tick;
    assign presc_nx  = presc_q + 6'h01;

    // tap0 = /8, tap2 = /32, tap8 = /128, tap32 = /512 of base
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            gear_cnt_q <= 4'h0;
            presc_q    <= 6'h00;
            taps_q     <= 4'h0;
        end
        else
        begin
            gear_cnt_q <= gear_cnt_q + 4'h1;
            taps_q     <= 4'h0;
            if (base_tick && pre_q == 3'h7)
            begin
                presc_q <= presc_nx; // one step per 8 base ticks
                taps_q  <= {presc_q[5:0] == 6'h3F, presc_q[3:0] == 4'hF,
                            presc_q[1:0] == 2'h3, 1'b1};
            end
        end
    end

    // a further /8 ahead of the prescaler gives the tap ratios
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            pre_q <= 3'h0;
        else if (base_tick)
            pre_q <= pre_q + 3'h1;
    end
    assign taps = taps_q;
endmodule

/* File: scbc_brg.sv */
// Purpose: baud divider with integer N and N + (16-K)/16 fractional mode
// Assumes: input strobe one cycle wide
// Notes:   fractional stretch spread by a phase accumulator
`timescale 1ns/10ps
module scbc_brg (
    input  wire logic                 clk,
    input  wire logic                 sys_rst,
    input  wire logic                 in_tick,
    input  wire scbc_pkg::scbc_baud_s cfg,
    input  wire logic                 frac_ok,
    output logic                      out_tick
);
    logic [4:0] cnt_q;
    logic [3:0] acc_q;
    logic       out_q;
    logic       stretch_q;
    logic [4:0] n_full;
    logic [4:0] limit;
    logic [4:0] acc_sum;

    // field 0 means divide by 16
    assign n_full  = (cfg.n == 4'h0) ? 5'd16 : {1'b0, cfg.n};
    // extra input clock in the period after the accumulator wraps
    assign limit   = stretch_q ? n_full : n_full - 5'd1;
    assign acc_sum = {1'b0, acc_q} + (5'd16 - {1'b0, cfg.k});

    // integer when fraction off, fraction ignored
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            cnt_q     <= 5'd0;
            acc_q     <= 4'h0;
            out_q     <= 1'b0;
            stretch_q <= 1'b0;
        end
        else
        begin
            out_q <= 1'b0;
            if (in_tick)
            begin
                if (cnt_q >= limit)
                begin
                    cnt_q <= 5'd0;
                    out_q <= 1'b1;
                    if (cfg.fen && frac_ok)
                    begin
                        acc_q     <= acc_sum[3:0];
                        stretch_q <= acc_sum[4];
                    end
                    else
                    begin
                        acc_q     <= 4'h0;
                        stretch_q <= 1'b0;
                    end
                end
                else
                    cnt_q <= cnt_q + 5'd1;
            end
        end
    end
    assign out_tick = out_q;
endmodule

/* File: scbc_top.sv */
// What this block does
// - shift mode 0 or asynchronous modes 1-3 of 7, 8, 9 data bits.
// - parity may be appended in 7 and 8 bit modes, never in 9 bit.
// - 9 bit mode offers wakeup of selected slaves on a shared link.
// - in 9 bit mode bit 8 high marks address, low marks data.
// - a 6-bit prescaler shared with timers feeds the baud generator.
// - a 2-bit field picks tap0, tap2, tap8 or tap32.
// - taps are base clock divided by 8, 32, 128 and 512.
// - divider supports divide by 1, integer N to 16, or N+(16-K)/16.
// - fraction disabled gives integer divide by N, fraction field ignored.
// - fraction enabled divides by N+(16-K)/16, N 2..15, K 1..15.
// - bit rate is generator output over 16 async, over 2 shift.
// - external clock async gives rate /16, period at least 4 clocks.
// - external clock in shift mode gives rate equal, period at least 16.
// - async clock source picks generator, io clock, timer match, or pin.
// - shift mode with output pin halves generator output as shift clock.
// Purpose: clocking and mode control of one serial channel, AXI4-Lite slave
// Assumes: pin and trigger inputs synchronous to clk
// Notes:   emits bit-rate strobes and the shift clock level
//
// Decided for this implementation: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/10ps
module scbc_top (
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        slow_tick,
    input  wire logic        io_clk_tick,
    input  wire logic        timer_match_trigger,
    input  wire logic        shift_clock_pin_zero_i,
    output logic             shift_clock_pin_zero_o,
    output logic             shift_clock_pin_zero_oe,
    output logic             sample_tick,
    output logic             bit_tick,
    output logic [1:0]       frame_mode,
    output logic [3:0]       frame_data_bits,
    output logic             parity_active,
    output logic             wakeup_active
);
    logic [5:0]           mode_q;
    scbc_pkg::scbc_baud_s baud_q;
    logic [3:0]           clkcfg_q;
    logic [8:0]           wake_q;
    logic                 ext_err_q;
    logic                 aw_got_q;
    logic                 w_got_q;
    logic [7:0]           awaddr_q;
    logic [31:0]          wdata_q;
    logic                 bvalid_q;
    logic [1:0]           bresp_q;
    logic                 rvalid_q;
    logic [31:0]          rdata_q;
    logic [1:0]           rresp_q;
    logic [3:0]           taps;
    logic                 tap_sel;
    logic                 brg_tick;
    logic                 pin_q;
    logic                 pin_rise;
    logic [4:0]           ext_cnt_q;
    logic [3:0]           os_cnt_q;
    logic                 half_q;
    logic                 sclk_q;
    logic                 sample_q;
    logic                 bit_q;
    scbc_pkg::scbc_mode_e mode;
    scbc_pkg::scbc_src_e  src;
    logic                 is_shift;
    logic                 pin_in;
    logic                 frac_ok;
    logic                 clk_src_tick;
    logic                 ext_min_ok;
    logic [4:0]           ext_min;
    logic                 do_write;
    logic [7:0]           w_addr;
    logic [31:0]          w_data;

    // register map helper: true when addr hits a mapped word
    function automatic logic mapped(input logic [7:0] a);
        mapped = (a == scbc_pkg::OFF_MODE) || (a == scbc_pkg::OFF_BAUD) ||
                 (a == scbc_pkg::OFF_FRAC) || (a == scbc_pkg::OFF_CLKCFG) ||
                 (a == scbc_pkg::OFF_STATUS) || (a == scbc_pkg::OFF_WAKE);
    endfunction

    // mode and source decode
    assign mode     = scbc_pkg::scbc_mode_e'(mode_q[scbc_pkg::MODE_LSB +: 2]);
    assign src      = scbc_pkg::scbc_src_e'(mode_q[scbc_pkg::SRC_LSB +: 2]);
    assign is_shift = (mode == scbc_pkg::SCBC_SHIFT);
    assign pin_in   = mode_q[scbc_pkg::DIR_BIT];
    // fraction honoured only async with N in 2..15; guards against misuse
    assign frac_ok  = !is_shift && (baud_q.n > 4'h1);

    // frame shape outputs
    assign frame_mode      = mode_q[scbc_pkg::MODE_LSB +: 2];
    assign frame_data_bits = is_shift ? 4'd8 :
                             (mode == scbc_pkg::SCBC_ASYNC7) ? 4'd7 :
                             (mode == scbc_pkg::SCBC_ASYNC8) ? 4'd8 : 4'd9;
    assign parity_active   = mode_q[scbc_pkg::PAR_BIT] &&
                             ((mode == scbc_pkg::SCBC_ASYNC7) ||
                              (mode == scbc_pkg::SCBC_ASYNC8));
    assign wakeup_active   = (mode == scbc_pkg::SCBC_ASYNC9);

    scbc_presc u_presc (
        .clk       (clk),
        .sys_rst   (sys_rst),
        .gear      (clkcfg_q[scbc_pkg::GEAR_LSB +: 3]),
        .slow_sel  (clkcfg_q[scbc_pkg::SLOW_BIT]),
        .slow_tick (slow_tick),
        .taps      (taps)
    );

    // one of four taps drives the generator
    assign tap_sel = taps[baud_q.tap];

    scbc_brg u_brg (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .in_tick  (tap_sel),
        .cfg      (baud_q),
        .frac_ok  (frac_ok),
        .out_tick (brg_tick)
    );

    // external pin edge and minimum period
    assign pin_rise   = shift_clock_pin_zero_i && !pin_q;
    assign ext_min    = is_shift ? 5'(scbc_pkg::EXT_MIN_SYNC) : 5'(scbc_pkg::EXT_MIN_ASYNC);
    assign ext_min_ok = (ext_cnt_q >= ext_min - 5'd1);
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            pin_q     <= 1'b1;
            ext_cnt_q <= 5'd0;
            ext_err_q <= 1'b0;
        end
        else
        begin
            pin_q <= shift_clock_pin_zero_i;
            if (pin_rise)
                ext_cnt_q <= 5'd0;
            else if (ext_cnt_q != 5'h1F)
                ext_cnt_q <= ext_cnt_q + 5'd1;
            // sticky; set wins over a software clear in the same cycle
            if (pin_rise && !ext_min_ok && (pin_in || src == scbc_pkg::SCBC_SRC_EXT))
                ext_err_q <= 1'b1;
            else if (do_write && w_addr == scbc_pkg::OFF_STATUS && w_data[0])
                ext_err_q <= 1'b0;
        end
    end

    // async basic clock source; timer match only meaningful here
    always_comb
    begin
        case (src)
            scbc_pkg::SCBC_SRC_BRG: clk_src_tick = brg_tick;
            scbc_pkg::SCBC_SRC_IO:  clk_src_tick = io_clk_tick;
            scbc_pkg::SCBC_SRC_TMR: clk_src_tick = timer_match_trigger;
            scbc_pkg::SCBC_SRC_EXT: clk_src_tick = pin_rise;
            default:                clk_src_tick = brg_tick;
        endcase
    end

    // bit rate: async /16 of source, shift /2 of generator or one per pin edge
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            os_cnt_q <= 4'h0;
            half_q   <= 1'b0;
            sclk_q   <= 1'b1;
            sample_q <= 1'b0;
            bit_q    <= 1'b0;
        end
        else
        begin
            sample_q <= 1'b0;
            bit_q    <= 1'b0;
            if (!is_shift)
            begin
                if (clk_src_tick)
                begin
                    sample_q <= 1'b1;
                    os_cnt_q <= os_cnt_q + 4'h1;
                    bit_q    <= (os_cnt_q == 4'(scbc_pkg::OVERSAMPLE - 1));
                end
            end
            else if (pin_in)
                bit_q <= pin_rise; // one bit per external edge
            else if (brg_tick)
            begin
                half_q <= !half_q;
                sclk_q <= !sclk_q; // shift clock toggles, full period = 2 ticks
                bit_q  <= half_q;
            end
        end
    end

    assign sample_tick             = sample_q;
    assign bit_tick                = bit_q;
    assign shift_clock_pin_zero_o  = sclk_q;
    assign shift_clock_pin_zero_oe = is_shift && !pin_in;

    // AXI write: address and data taken in either order
    assign s_axi_awready = !aw_got_q && !bvalid_q;
    assign s_axi_wready  = !w_got_q && !bvalid_q;
    assign w_addr   = (s_axi_awvalid && s_axi_awready) ? s_axi_awaddr : awaddr_q;
    assign w_data   = (s_axi_wvalid && s_axi_wready) ? s_axi_wdata : wdata_q;
    assign do_write = (aw_got_q || (s_axi_awvalid && s_axi_awready)) &&
                      (w_got_q || (s_axi_wvalid && s_axi_wready)) && !bvalid_q;

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            aw_got_q <= 1'b0;
            w_got_q  <= 1'b0;
            awaddr_q <= 8'h00;
            wdata_q  <= 32'h0000_0000;
            bvalid_q <= 1'b0;
            bresp_q  <= 2'h0;
            mode_q   <= scbc_pkg::RST_MODE;
            baud_q   <= {scbc_pkg::RST_BAUD, scbc_pkg::RST_FRAC};
            clkcfg_q <= scbc_pkg::RST_CLK;
            wake_q   <= 9'h000;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_got_q <= 1'b1;
                awaddr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_got_q <= 1'b1;
                wdata_q <= s_axi_wdata;
            end
            if (do_write)
            begin
                aw_got_q <= 1'b0;
                w_got_q  <= 1'b0;
                bvalid_q <= 1'b1;
                bresp_q  <= mapped(w_addr) ? 2'h0 : 2'h2;
                if (s_axi_wstrb[0] || s_axi_wstrb == 4'h0 || w_got_q)
                begin
                    case (w_addr)
                        scbc_pkg::OFF_MODE:   mode_q   <= w_data[5:0];
                        scbc_pkg::OFF_BAUD:   {baud_q.fen, baud_q.tap, baud_q.n} <= w_data[6:0];
                        scbc_pkg::OFF_FRAC:   baud_q.k <= w_data[3:0];
                        scbc_pkg::OFF_CLKCFG: clkcfg_q <= w_data[3:0];
                        scbc_pkg::OFF_WAKE:   wake_q   <= {w_data[8], w_data[7:0]};
                        default:              ;
                    endcase
                end
            end
            else if (bvalid_q && s_axi_bready)
                bvalid_q <= 1'b0;
        end
    end
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp  = bresp_q;

    // AXI read; status shows live clock state, wake word shows frame class
    assign s_axi_arready = !rvalid_q;
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            rvalid_q <= 1'b0;
            rdata_q  <= 32'h0000_0000;
            rresp_q  <= 2'h0;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            rvalid_q <= 1'b1;
            rresp_q  <= mapped(s_axi_araddr) ? 2'h0 : 2'h2;
            case (s_axi_araddr)
                scbc_pkg::OFF_MODE:   rdata_q <= {26'h0, mode_q};
                scbc_pkg::OFF_BAUD:   rdata_q <= {25'h0, baud_q.fen, baud_q.tap, baud_q.n};
                scbc_pkg::OFF_FRAC:   rdata_q <= {28'h0, baud_q.k};
                scbc_pkg::OFF_CLKCFG: rdata_q <= {28'h0, clkcfg_q};
                scbc_pkg::OFF_STATUS: rdata_q <= {26'h0, wakeup_active, parity_active,
                                                  sclk_q, os_cnt_q == 4'h0, frac_ok, ext_err_q};
                scbc_pkg::OFF_WAKE:   rdata_q <= {22'h0, wake_q[8] && wakeup_active,
                                                  wake_q};
                default:              rdata_q <= 32'h0000_0000;
            endcase
        end
        else if (rvalid_q && s_axi_rready)
            rvalid_q <= 1'b0;
    end
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata  = rdata_q;
    assign s_axi_rresp  = rresp_q;
endmodule

/* File: scbc_peer.sv */
// Purpose: far-side clock source driving the channel clock pin
// Assumes: half period given in system clocks, at least one
// Notes:   pin rests high between frames, as a pulled-up line does
`timescale 1ns/10ps
module scbc_peer (
    input  wire logic       clk,
    input  wire logic       run,
    input  wire logic [4:0] half,
    output logic            pin
);
    logic [4:0] cnt_q;

    // bench sets the period; too short a period is a deliberate fault only
    always_ff @(posedge clk)
    begin
        if (!run)
        begin
            cnt_q <= 5'h00;
            pin   <= 1'b1;
        end
        else if (cnt_q == half - 5'h01)
        begin
            cnt_q <= 5'h00;
            pin   <= ~pin;
        end
        else
            cnt_q <= cnt_q + 5'h01;
    end
endmodule

/* File: scbc_top_monitor.sv */
// Purpose: port-level checks for the serial channel clocking block
// Assumes: one clock domain, synchronous active-high reset
// Notes:   bound to every instance of the top module
`timescale 1ns/10ps
module scbc_top_monitor (
    input wire logic        clk,
    input wire logic        sys_rst,
    input wire logic [7:0]  s_axi_araddr,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        shift_clock_pin_zero_oe,
    input wire logic [1:0]  frame_mode,
    input wire logic [3:0]  frame_data_bits,
    input wire logic        parity_active,
    input wire logic        wakeup_active
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    // bus answers stand until taken
    resp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write answer dropped early");
    read_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer changed early");
    aw_blocked_a: assert property (s_axi_bvalid |-> !s_axi_awready)
        else $error("new write taken while answer pending");
    read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    bad_addr_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h14
        |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
        else $error("unmapped read not refused");
    // frame decoding follows the mode field
    data_bits_a: assert property (frame_data_bits == (frame_mode == 2'h1 ? 4'h7 :
        frame_mode == 2'h3 ? 4'h9 : 4'h8)) else $error("data width wrong for mode");
    parity_mode_a: assert property (parity_active |-> frame_mode inside {2'h1, 2'h2})
        else $error("parity outside 7 or 8 bit mode");
    wake_mode_a: assert property (wakeup_active == (frame_mode == 2'h3))
        else $error("wakeup flag wrong for mode");
    pin_drive_a: assert property (shift_clock_pin_zero_oe |-> frame_mode == 2'h0)
        else $error("clock pin driven outside shift mode");
endmodule

bind scbc_top scbc_top_monitor mon (.clk(clk), .sys_rst(sys_rst), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .s_axi_awready(s_axi_awready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .shift_clock_pin_zero_oe(shift_clock_pin_zero_oe), .frame_mode(frame_mode),
    .frame_data_bits(frame_data_bits), .parity_active(parity_active),
    .wakeup_active(wakeup_active));

/* File: scbc_top_tb.sv */
// Purpose: self-checking bench for the serial channel clocking block
// Assumes: 50 MHz clock, reset held for 20 cycles
// Notes:   tick periods are counted in system clocks from the second tick after a change
`timescale 1ns/10ps
module scbc_top_tb;
    logic        clk, sys_rst, awv, wv, bv, bre, arv, rv, rre, awr, wr_, arr;
    logic        slow, io, tmr, run, pin, po, poe, st, bt, par, wak;
    logic [7:0]  awa, ara;
    logic [31:0] wd, rdat;
    logic [1:0]  bresp, rresp, fm;
    logic [3:0]  fdb;
    logic [4:0]  half;
    int          cyc = 0;
    int          err_total = 0;
    int          checked = 0;

    scbc_top uut (.clk(clk), .sys_rst(sys_rst), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
        .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
        .s_axi_wready(wr_), .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(bre),
        .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdat),
        .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rre), .slow_tick(slow),
        .io_clk_tick(io), .timer_match_trigger(tmr), .shift_clock_pin_zero_i(pin),
        .shift_clock_pin_zero_o(po), .shift_clock_pin_zero_oe(poe), .sample_tick(st),
        .bit_tick(bt), .frame_mode(fm), .frame_data_bits(fdb), .parity_active(par),
        .wakeup_active(wak));
    scbc_peer peer (.clk(clk), .run(run), .half(half), .pin(pin));

    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // side strobes at fixed rates, and the hang limit
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        slow <= (cyc % 3 == 0);
        io <= (cyc % 5 == 0);
        tmr <= (cyc % 7 == 0);
        if (cyc == 40000)
        begin
            err_total++;
            final_report;
        end
    end

    task automatic chk_v(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            err_total++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_n(input int got, input int exp);
        checked++;
        if (got != exp)
        begin
            err_total++;
            $display("Error at %0t: period %0d expected %0d", $time, got, exp);
        end
    endtask

    // both halves offered together, each released as it is taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge clk);
        awa <= a;
        wd <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        do
        begin
            @(posedge clk);
            if (awr) awv <= 1'b0;
            if (wr_) wv <= 1'b0;
        end while ((awv && !awr) || (wv && !wr_));
        while (bv !== 1'b1) @(posedge clk);
        bre <= 1'b1;
        @(posedge clk);
        chk_v(32'(bresp), 32'(er));
        bre <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clk);
        ara <= a;
        arv <= 1'b1;
        rre <= 1'b1;
        do @(posedge clk); while (arr !== 1'b1);
        arv <= 1'b0;
        do @(posedge clk); while (rv !== 1'b1);
        d = rdat;
        r = rresp;
        rre <= 1'b0;
    endtask

    // sum of n tick intervals, measured from the second tick after a change
    task automatic per(input logic use_bit, input int n, input int exp);
        int c;
        c = 0;
        for (int i = 0; i <= n + 1; i++)
        begin
            do
            begin
                @(posedge clk);
                c++;
            end while ((use_bit ? bt : st) !== 1'b1);
            if (i == 1) c = 0;
        end
        chk_n(c, exp);
    endtask

    task automatic t_regs;
        logic [31:0] d;
        logic [1:0]  r;
        rd(8'h04, d, r);
        chk_v(d, 32'h0);
        rd(8'h18, d, r);
        chk_v({d[31:2], r}, 32'h2);
        wr(8'h18, 32'h1, 2'h2);
        wr(8'h04, 32'h5A, 2'h0);
        rd(8'h04, d, r);
        chk_v(d, 32'h5A);
        $display("test registers done");
    endtask

    task automatic t_rates;
        wr(8'h00, 32'h2, 2'h0);
        for (int t = 3; t >= 0; t--)
        begin
            wr(8'h04, 32'h1 | (t << 4), 2'h0);
            per(1'b0, 1, 8 << (2 * t));
        end
        wr(8'h0C, 32'h1, 2'h0);
        per(1'b0, 1, 16);
        wr(8'h0C, 32'h8, 2'h0);
        per(1'b0, 1, 24);
        wr(8'h0C, 32'h0, 2'h0);
        wr(8'h04, 32'h0, 2'h0);
        per(1'b0, 1, 128);
        wr(8'h08, 32'h5, 2'h0);
        wr(8'h04, 32'h3, 2'h0);
        per(1'b0, 1, 24);
        wr(8'h08, 32'h8, 2'h0);
        wr(8'h04, 32'h42, 2'h0);
        per(1'b0, 16, 320);
        wr(8'h04, 32'h1, 2'h0);
        per(1'b1, 1, 128);
        wr(8'h00, 32'h6, 2'h0);
        per(1'b0, 1, 5);
        wr(8'h00, 32'hA, 2'h0);
        per(1'b0, 1, 7);
        $display("test rates done");
    endtask

    task automatic t_pins;
        half <= 5'h04;
        run <= 1'b1;
        wr(8'h00, 32'hE, 2'h0);
        per(1'b0, 1, 8);
        half <= 5'h08;
        wr(8'h00, 32'h20, 2'h0);
        per(1'b1, 1, 16);
        chk_v(32'(poe), 32'h0);
        run <= 1'b0;
        wr(8'h00, 32'h0, 2'h0);
        per(1'b1, 1, 16);
        chk_v(32'(poe), 32'h1);
        $display("test pins done");
    endtask

    task automatic t_modes;
        logic [31:0] d;
        logic [1:0]  r;
        for (int m = 0; m < 4; m++)
        begin
            wr(8'h00, 32'h10 | m, 2'h0);
            chk_v(32'(fdb), (m == 1) ? 32'h7 : (m == 3) ? 32'h9 : 32'h8);
            chk_v({par, wak}, {m == 1 || m == 2, m == 3});
        end
        wr(8'h14, 32'h100, 2'h0);
        rd(8'h14, d, r);
        chk_v(32'(d[9]), 32'h1);
        wr(8'h14, 32'hFF, 2'h0);
        rd(8'h14, d, r);
        chk_v(32'(d[9]), 32'h0);
        $display("test modes done");
    endtask

    task automatic final_report;
        $display("comparisons %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    initial
    begin
        sys_rst = 1'b1;
        {awv, wv, bre, arv, rre, run} = 6'h00;
        {awa, ara, wd, half} = 53'h0;
        repeat (20) @(posedge clk);
        sys_rst <= 1'b0;
        t_regs;
        t_rates;
        t_pins;
        t_modes;
        final_report;
    end
endmodule
